// ### rtl/stfe_pkg.sv
// Operation
// RULE1 - A node address field sends one byte holding the node address of the user.
// RULE2 - In produce direction a constant field's value is sent exactly as configured.
// RULE3 - In consume direction a constant field is compared and a mismatch drops the telegram.
// RULE4 - A limit field is refused in produce direction and aborts that transaction.
// RULE5 - A received limit field outside its lower and upper bound drops the telegram.
// RULE6 - A produce data field copies its block from the data area into the telegram.
// RULE7 - A consume data field copies received bytes into the data area.
// RULE8 - The controller supplies an end or length character for produce variable data.
// RULE9 - Sending variable data forwards or strips the end or length character as set.
// RULE10 - Receiving variable data, the block makes the end or length character itself.
// RULE11 - Receiving variable data, that character is passed up or left out as set.
// RULE12 - A checksum field carries the sum of the telegram at its position.
// RULE13 - Fields are handled strictly in ascending order of position.
// RULE14 - The transaction direction selects produce or consume handling of every field.
package stfe_pkg;

	// ==========================================
	// Register map (byte addresses)
	localparam logic [11:0] REG_CTRL = 12'h000;
	localparam logic [11:0] REG_STAT = 12'h004;
	localparam logic [11:0] REG_EVT = 12'h008;
	localparam logic [11:0] REG_MASK = 12'h00C;
	localparam logic [11:0] REG_DATA = 12'h010;
	localparam logic [11:0] REG_FLD = 12'h100;
	localparam logic [31:0] RST_WORD = 32'h0000_0000;

	// ==========================================
	// Control fields
	localparam int CTL_GO = 0;
	localparam int CTL_DIR = 1;
	localparam int CTL_XOR = 2;
	localparam int CTL_NODE = 8;
	localparam int CTL_END = 16;

	// ==========================================
	// Event bits
	localparam int EV_DONE = 0;
	localparam int EV_DROP = 1;
	localparam int EV_ERR = 2;
	localparam int EV_W = 3;

	// ==========================================
	// Sizes
	localparam logic [3:0] FLD_N = 4'h8;
	localparam logic [4:0] BUF_N = 5'h10;

	// ==========================================
	// Field types
	localparam logic [2:0] FT_NONE = 3'h0;
	localparam logic [2:0] FT_NODE = 3'h1;
	localparam logic [2:0] FT_CONST = 3'h2;
	localparam logic [2:0] FT_LIMIT = 3'h3;
	localparam logic [2:0] FT_DATA = 3'h4;
	localparam logic [2:0] FT_VAR = 3'h5;
	localparam logic [2:0] FT_CSUM = 3'h6;

	// Field descriptor word
	typedef struct packed {
		logic [18:0] rsv_hi;
		logic [4:0] len;
		logic [2:0] rsv_lo;
		logic pass;
		logic lenmode;
		logic [2:0] ftype;
	} stfe_fld_t;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_PROD = 2'b01,
		ST_CONS = 2'b10
	} stfe_st_t;

endpackage

// ### rtl/stfe_csum.sv
`timescale 1ns/1ps
// ==========================================
// Running checksum, additive or xor
module stfe_csum import stfe_pkg::*; (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// Control
	input wire logic clr_i,
	input wire logic en_i,
	input wire logic xor_i,
	input wire logic [7:0] byte_i,
	// Result
	output logic [7:0] sum_o
);

	logic [7:0] sum_reg;
	logic [7:0] sum_next;

	// Clear has priority so a new telegram never inherits old bytes
	always_comb begin
		sum_next = sum_reg;
		if (clr_i) begin
			sum_next = 8'h00;
		end else if (en_i) begin
			sum_next = xor_i ? (sum_reg ^ byte_i) : 8'(sum_reg + byte_i); // RULE12
		end
	end

	// Register
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			sum_reg <= 8'h00;
		end else begin
			sum_reg <= sum_next;
		end
	end

	assign sum_o = sum_reg;

endmodule

// ### rtl/stfe_engine.sv
`timescale 1ns/1ps
module stfe_engine import stfe_pkg::*; (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// APB slave
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [11:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	input wire logic [3:0] pstrb_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	// Serial transmit bytes
	output logic tx_valid_o,
	output logic [7:0] tx_data_o,
	input wire logic tx_ready_i,
	// Serial receive bytes
	input wire logic rx_valid_i,
	input wire logic [7:0] rx_data_i,
	input wire logic rx_last_i,
	// Interrupt
	output logic irq_o
);

	// ==========================================
	// Helpers
	function automatic logic [31:0] wmerge(logic [31:0] o, logic [31:0] n, logic [3:0] s);
		logic [31:0] r;
		r = o;
		for (int k = 0; k < 4; k++) begin
			if (s[k]) begin
				r[8*k +: 8] = n[8*k +: 8];
			end
		end
		return r;
	endfunction

	// Width of a constant or limit field, 1 to 4 bytes
	function automatic logic [4:0] vlen(logic [4:0] l);
		return (l == 5'h00) ? 5'h01 : ((l > 5'h04) ? 5'h04 : l);
	endfunction

	// Big-endian byte of a configured value
	function automatic logic [7:0] byte_of(logic [31:0] v, logic [4:0] l, logic [4:0] i);
		logic [31:0] t;
		t = v >> {5'(vlen(l) - 5'h01 - i), 3'b000};
		return t[7:0];
	endfunction

	// ==========================================
	// Config registers
	logic [31:0] ctrl_reg, ctrl_next, mask_reg, mask_next;
	stfe_fld_t fd_reg [8];
	stfe_fld_t fd_next [8];
	logic [31:0] lo_reg [8];
	logic [31:0] lo_next [8];
	logic [31:0] hi_reg [8];
	logic [31:0] hi_next [8];
	// APB answer
	logic [31:0] prdata_reg, prdata_next;
	logic pready_reg, pready_next, pslverr_reg, pslverr_next, irq_reg, irq_next;
	// Engine
	stfe_st_t st_reg, st_next;
	logic [3:0] fidx_reg, fidx_next;
	logic [4:0] bcnt_reg, bcnt_next, dptr_reg, dptr_next, vst_reg, vst_next;
	logic [7:0] vrem_reg, vrem_next, txd_reg, txd_next;
	logic [31:0] acc_reg, acc_next;
	logic bad_reg, bad_next, txv_reg, txv_next;
	logic [7:0] dbuf_reg [16];
	logic [7:0] dbuf_next [16];
	logic [7:0] rbuf_reg [16];
	logic [7:0] rbuf_next [16];
	logic [EV_W-1:0] evt_reg, evt_next, evset;
	logic cs_clr, cs_en, commit;
	logic [7:0] cs_byte, sum;

	logic acc_ph, wr, rd_evt, map_ok;
	logic [2:0] fi;
	stfe_fld_t cur;
	logic [31:0] cval, chi;
	logic [7:0] node, endc;
	logic fin_cur, last, stall;
	assign acc_ph = psel_i && penable_i && pready_reg;
	assign wr = acc_ph && pwrite_i;
	assign rd_evt = acc_ph && !pwrite_i && (paddr_i == REG_EVT);
	assign fi = paddr_i[6:4];
	assign map_ok = (paddr_i[11:5] == 7'h00) ||
		((paddr_i[11:7] == REG_FLD[11:7]) && (paddr_i[3:2] != 2'b11) && (paddr_i[1:0] == 2'b00));
	assign cur = fd_reg[fidx_reg[2:0]];
	assign cval = lo_reg[fidx_reg[2:0]];
	assign chi = hi_reg[fidx_reg[2:0]];
	assign node = ctrl_reg[CTL_NODE +: 8];
	assign endc = ctrl_reg[CTL_END +: 8];
	assign fin_cur = (fidx_reg >= FLD_N) || (cur.ftype == FT_NONE);
	assign last = (bcnt_reg + 5'h01) >= ((cur.ftype == FT_DATA) ? ((cur.len == 5'h00) ? 5'h01 :
		cur.len) : vlen(cur.len));
	assign stall = txv_reg && !tx_ready_i;

	// ==========================================
	// APB register side; answer comes one cycle into the access phase
	always_comb begin
		ctrl_next = ctrl_reg;
		mask_next = mask_reg;
		fd_next = fd_reg;
		lo_next = lo_reg;
		hi_next = hi_reg;
		pready_next = psel_i && penable_i && !pready_reg;
		prdata_next = prdata_reg;
		pslverr_next = 1'b0;
		if (pready_next) begin
			pslverr_next = !map_ok;
			prdata_next = RST_WORD;
			if (paddr_i == REG_CTRL) prdata_next = {ctrl_reg[31:1], 1'b0};
			else if (paddr_i == REG_STAT) prdata_next = {24'h0, fidx_reg, 2'b00, st_reg};
			else if (paddr_i == REG_EVT) prdata_next = {29'h0, evt_reg};
			else if (paddr_i == REG_MASK) prdata_next = mask_reg;
			else if (paddr_i[11:4] == REG_DATA[11:4])
				prdata_next = {dbuf_reg[{paddr_i[3:2], 2'd3}], dbuf_reg[{paddr_i[3:2], 2'd2}],
					dbuf_reg[{paddr_i[3:2], 2'd1}], dbuf_reg[{paddr_i[3:2], 2'd0}]};
			else if (map_ok && paddr_i[3:2] == 2'b00) prdata_next = fd_reg[fi];
			else if (map_ok && paddr_i[3:2] == 2'b01) prdata_next = lo_reg[fi];
			else if (map_ok) prdata_next = hi_reg[fi];
		end
		if (wr && map_ok) begin
			if (paddr_i == REG_CTRL) ctrl_next = wmerge(ctrl_reg, pwdata_i, pstrb_i); // RULE14
			else if (paddr_i == REG_MASK) mask_next = wmerge(mask_reg, pwdata_i, pstrb_i);
			else if (paddr_i[11:8] == REG_FLD[11:8]) begin
				if (paddr_i[3:2] == 2'b00) fd_next[fi] = wmerge(fd_reg[fi], pwdata_i, pstrb_i);
				else if (paddr_i[3:2] == 2'b01) lo_next[fi] = wmerge(lo_reg[fi], pwdata_i, pstrb_i);
				else hi_next[fi] = wmerge(hi_reg[fi], pwdata_i, pstrb_i);
			end
		end
		ctrl_next[CTL_GO] = 1'b0;
	end

	// ==========================================
	// Frame engine, one byte per cycle in ascending field order
	always_comb begin
		logic [7:0] b;
		logic [31:0] av;
		logic [3:0] nxt;
		logic adv, emit, done_ok;
		b = 8'h00;
		av = 32'h0;
		nxt = 4'h0;
		adv = 1'b0;
		emit = 1'b0;
		done_ok = 1'b0;
		st_next = st_reg;
		fidx_next = fidx_reg;
		bcnt_next = bcnt_reg;
		dptr_next = dptr_reg;
		vst_next = vst_reg;
		vrem_next = vrem_reg;
		acc_next = acc_reg;
		bad_next = bad_reg;
		txv_next = txv_reg;
		txd_next = txd_reg;
		dbuf_next = dbuf_reg;
		rbuf_next = rbuf_reg;
		evset = '0;
		cs_clr = 1'b0;
		cs_en = 1'b0;
		cs_byte = 8'h00;
		commit = 1'b0;
		if (wr && paddr_i[11:4] == REG_DATA[11:4]) begin
			for (int k = 0; k < 4; k++) begin
				if (pstrb_i[k]) dbuf_next[{paddr_i[3:2], 2'(k)}] = pwdata_i[8*k +: 8];
			end
		end
		case (st_reg)
			ST_IDLE: begin
				if (wr && paddr_i == REG_CTRL && pstrb_i[0] && pwdata_i[CTL_GO]) begin
					st_next = pwdata_i[CTL_DIR] ? ST_CONS : ST_PROD; // RULE14
					fidx_next = 4'h0;
					bcnt_next = 5'h00;
					dptr_next = 5'h00;
					acc_next = 32'h0;
					bad_next = 1'b0;
					cs_clr = 1'b1;
				end
			end
			ST_PROD: begin
				if (!stall) begin
					txv_next = 1'b0;
					if (fin_cur) begin
						st_next = ST_IDLE;
						evset[EV_DONE] = 1'b1;
					end else begin
						case (cur.ftype)
							FT_NODE: begin
								b = node; // RULE1
								emit = 1'b1;
								adv = 1'b1;
							end
							FT_CONST: begin
								b = byte_of(cval, cur.len, bcnt_reg); // RULE2
								emit = 1'b1;
								adv = last;
							end
							FT_DATA: begin
								b = dbuf_reg[dptr_reg[3:0]]; // RULE6
								emit = 1'b1;
								dptr_next = dptr_reg + 5'h01;
								adv = last || (dptr_reg == 5'h0F);
							end
							FT_VAR: begin
								b = dbuf_reg[dptr_reg[3:0]];
								dptr_next = dptr_reg + 5'h01;
								if (cur.lenmode && bcnt_reg == 5'h00) begin
									vrem_next = b; // RULE8
									emit = cur.pass; // RULE9
									bcnt_next = 5'h01;
									adv = (b == 8'h00);
								end else if (cur.lenmode) begin
									emit = 1'b1;
									vrem_next = vrem_reg - 8'h01;
									adv = (vrem_reg == 8'h01);
								end else begin
									emit = (b != endc) || cur.pass; // RULE9
									adv = (b == endc);
								end
								adv = adv || (dptr_reg == 5'h0F);
							end
							FT_CSUM: begin
								b = sum; // RULE12
								emit = 1'b1;
								adv = 1'b1;
							end
							default: begin
								// Limit or unknown type cannot be sent: abort
								st_next = ST_IDLE; // RULE4
								evset[EV_ERR] = 1'b1;
							end
						endcase
						if (emit) begin
							txv_next = 1'b1;
							txd_next = b;
							cs_en = (cur.ftype != FT_CSUM);
							cs_byte = b;
						end
						if (adv) begin
							fidx_next = fidx_reg + 4'h1; // RULE13
							bcnt_next = 5'h00;
						end else if (cur.ftype != FT_VAR) begin
							bcnt_next = bcnt_reg + 5'h01;
						end
					end
				end
			end
			ST_CONS: begin
				if (rx_valid_i) begin
					b = rx_data_i;
					cs_en = !fin_cur && (cur.ftype != FT_CSUM);
					cs_byte = b;
					if (fin_cur) begin
						bad_next = 1'b1;
					end else begin
						case (cur.ftype)
							FT_NODE: begin
								if (b != node) bad_next = 1'b1;
								adv = 1'b1;
							end
							FT_CONST: begin
								if (b != byte_of(cval, cur.len, bcnt_reg)) bad_next = 1'b1; // RULE3
								adv = last;
							end
							FT_LIMIT: begin
								av = {acc_reg[23:0], b};
								acc_next = av;
								if (last) begin
									if (av < cval || av > chi) bad_next = 1'b1; // RULE5
									acc_next = 32'h0;
								end
								adv = last;
							end
							FT_DATA: begin
								if (dptr_reg < BUF_N) rbuf_next[dptr_reg[3:0]] = b; // RULE7
								if (dptr_reg < BUF_N) dptr_next = dptr_reg + 5'h01;
								adv = last;
							end
							FT_VAR: begin
								// Reserve a slot for the length character ahead of the block
								if (bcnt_reg == 5'h00 && cur.lenmode && cur.pass) begin
									vst_next = dptr_reg;
									dptr_next = dptr_reg + 5'h01;
								end
								if (dptr_next < BUF_N) begin
									rbuf_next[dptr_next[3:0]] = b;
									dptr_next = dptr_next + 5'h01;
								end
								vrem_next = (bcnt_reg == 5'h00) ? 8'h01 : vrem_reg + 8'h01;
								bcnt_next = 5'h01;
							end
							FT_CSUM: begin
								if (b != sum) bad_next = 1'b1; // RULE12
								adv = 1'b1;
							end
							default: bad_next = 1'b1;
						endcase
						if (adv) begin
							fidx_next = fidx_reg + 4'h1; // RULE13
							bcnt_next = 5'h00;
						end else if (cur.ftype != FT_VAR) begin
							bcnt_next = bcnt_reg + 5'h01;
						end
					end
					if (rx_last_i) begin
						// Variable data runs to the end of the telegram
						if (!fin_cur && cur.ftype == FT_VAR && cur.pass) begin
							if (cur.lenmode) rbuf_next[vst_next[3:0]] = vrem_next; // RULE10 RULE11
							else if (dptr_next < BUF_N) rbuf_next[dptr_next[3:0]] = endc;
						end
						nxt = (!fin_cur && cur.ftype == FT_VAR) ? fidx_reg + 4'h1 : fidx_next;
						done_ok = (nxt >= FLD_N) || (fd_reg[nxt[2:0]].ftype == FT_NONE);
						st_next = ST_IDLE;
						if (bad_next || !done_ok) begin
							evset[EV_DROP] = 1'b1; // RULE3 RULE5
						end else begin
							commit = 1'b1;
							dbuf_next = rbuf_next;
							evset[EV_DONE] = 1'b1;
						end
					end
				end
			end
			default: st_next = ST_IDLE;
		endcase
		// A read clears only the bits it returned; a new event wins
		evt_next = (evt_reg & ~(rd_evt ? prdata_reg[EV_W-1:0] : '0)) | evset;
		irq_next = |(evt_next & mask_next[EV_W-1:0]);
	end

	stfe_csum u_csum (
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.clr_i(cs_clr),
		.en_i(cs_en),
		.xor_i(ctrl_reg[CTL_XOR]),
		.byte_i(cs_byte),
		.sum_o(sum)
	);

	// ==========================================
	// Register all state
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			ctrl_reg <= RST_WORD;
			mask_reg <= RST_WORD;
			fd_reg <= '{default: '0};
			lo_reg <= '{default: '0};
			hi_reg <= '{default: '0};
			prdata_reg <= RST_WORD;
			pready_reg <= 1'b0;
			pslverr_reg <= 1'b0;
			irq_reg <= 1'b0;
			st_reg <= ST_IDLE;
			fidx_reg <= 4'h0;
			bcnt_reg <= 5'h00;
			dptr_reg <= 5'h00;
			vst_reg <= 5'h00;
			vrem_reg <= 8'h00;
			txd_reg <= 8'h00;
			acc_reg <= 32'h0;
			bad_reg <= 1'b0;
			txv_reg <= 1'b0;
			dbuf_reg <= '{default: '0};
			rbuf_reg <= '{default: '0};
			evt_reg <= '0;
		end else begin
			ctrl_reg <= ctrl_next;
			mask_reg <= mask_next;
			fd_reg <= fd_next;
			lo_reg <= lo_next;
			hi_reg <= hi_next;
			prdata_reg <= prdata_next;
			pready_reg <= pready_next;
			pslverr_reg <= pslverr_next;
			irq_reg <= irq_next;
			st_reg <= st_next;
			fidx_reg <= fidx_next;
			bcnt_reg <= bcnt_next;
			dptr_reg <= dptr_next;
			vst_reg <= vst_next;
			vrem_reg <= vrem_next;
			txd_reg <= txd_next;
			acc_reg <= acc_next;
			bad_reg <= bad_next;
			txv_reg <= txv_next;
			dbuf_reg <= dbuf_next;
			rbuf_reg <= rbuf_next;
			evt_reg <= evt_next;
		end
	end

	assign prdata_o = prdata_reg;
	assign pready_o = pready_reg;
	assign pslverr_o = pslverr_reg;
	assign tx_valid_o = txv_reg;
	assign tx_data_o = txd_reg;
	assign irq_o = irq_reg;

	// ==========================================
	// Checks
	logic prod_go, cons_go;
	assign prod_go = (st_reg == ST_PROD) && !stall && !fin_cur;
	assign cons_go = (st_reg == ST_CONS) && rx_valid_i && !fin_cur;
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);

	a_node_byte: assert property (prod_go && cur.ftype == FT_NODE |=> // RULE1
		tx_valid_o && tx_data_o == $past(node)) else $error("node byte wrong");
	a_const_byte: assert property (prod_go && cur.ftype == FT_CONST |=> // RULE2
		tx_valid_o && tx_data_o == byte_of($past(cval), $past(cur.len), $past(bcnt_reg)))
		else $error("constant byte altered");
	a_const_drop: assert property (cons_go && cur.ftype == FT_CONST && // RULE3
		rx_data_i != byte_of(cval, cur.len, bcnt_reg) |=> bad_reg && !$past(commit))
		else $error("constant mismatch not dropped");
	a_limit_abort: assert property (prod_go && cur.ftype == FT_LIMIT |=> // RULE4
		!tx_valid_o && st_reg == ST_IDLE && evt_reg[EV_ERR]) else $error("limit sent");
	a_limit_drop: assert property (cons_go && cur.ftype == FT_LIMIT && last && // RULE5
		({acc_reg[23:0], rx_data_i} > chi) |=> bad_reg || st_reg == ST_IDLE)
		else $error("limit breach kept");
	a_data_copy: assert property (prod_go && cur.ftype == FT_DATA |=> // RULE6
		tx_data_o == $past(dbuf_reg[dptr_reg[3:0]])) else $error("data byte wrong");
	a_rx_store: assert property (cons_go && cur.ftype == FT_DATA && dptr_reg < BUF_N |=> // RULE7
		rbuf_reg[$past(dptr_reg[3:0])] == $past(rx_data_i)) else $error("rx byte lost");
	a_var_strip: assert property (prod_go && cur.ftype == FT_VAR && !cur.lenmode && // RULE9
		!cur.pass && dbuf_reg[dptr_reg[3:0]] == endc |=> !tx_valid_o)
		else $error("end char not stripped");
	a_csum_tx: assert property (prod_go && cur.ftype == FT_CSUM |=> // RULE12
		tx_data_o == $past(sum)) else $error("checksum byte wrong");
	a_field_order: assert property (st_reg != ST_IDLE && $past(st_reg) != ST_IDLE |-> // RULE13
		fidx_reg >= $past(fidx_reg)) else $error("field order broken");
	a_irq_level: assert property (irq_o == |(evt_reg & mask_reg[EV_W-1:0]))
		else $error("irq out of step");

	c_prod_done: cover property (st_reg == ST_PROD ##1 st_reg == ST_IDLE && evt_reg[EV_DONE]);
	c_cons_commit: cover property (commit);
	c_drop: cover property (evset[EV_DROP]);
	c_tx_stall: cover property (stall [*3]);

endmodule

// ### dv/stfe_peer.sv
`timescale 1ns/1ps
// ==========================================
// Serial far side: stalling byte sink and byte source
module stfe_peer (
	// Clock
	input wire logic clk_i,
	// Bytes from the engine
	input wire logic tx_valid_i,
	input wire logic [7:0] tx_data_i,
	output logic tx_ready_o,
	// Bytes towards the engine
	output logic rx_valid_o,
	output logic [7:0] rx_data_o,
	output logic rx_last_o
);
	logic [7:0] got[$];
	bit hold = 1'b0;

	// Idle values from time zero
	initial begin
		tx_ready_o = 1'b0;
		rx_valid_o = 1'b0;
		rx_data_o = 8'h5A;
		rx_last_o = 1'b0;
	end

	// A byte counts only at an edge with valid and ready; stalls are random
	always @(posedge clk_i) begin
		if (tx_valid_i && tx_ready_o)
			got.push_back(tx_data_i);
		tx_ready_o <= !hold && ($urandom_range(3) != 0);
	end

	// One byte per pulse, one idle cycle between bytes
	task automatic send(input logic [7:0] b[$]);
		for (int k = 0; k < b.size(); k++) begin
			@(posedge clk_i);
			rx_valid_o <= 1'b1;
			rx_data_o <= b[k];
			rx_last_o <= (k == b.size() - 1);
			@(posedge clk_i);
			rx_valid_o <= 1'b0;
			rx_data_o <= ~b[k]; // Stale data must never look like the last byte
			rx_last_o <= 1'b0;
		end
	endtask
endmodule

// ### dv/serial_telegram_field_engine_tb.sv
`timescale 1ns/1ps
// ==========================================
// Bench: telegrams checked against a queue model
module serial_telegram_field_engine_tb import stfe_pkg::*; ;
	localparam logic [7:0] END_CH = 8'h0D;
	logic clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic tx_valid;
	logic [7:0] tx_data;
	logic tx_ready;
	logic rx_valid;
	logic [7:0] rx_data;
	logic rx_last;
	logic irq;
	logic [7:0] node;
	logic [31:0] mask;
	int err_count = 0;
	int samples_checked = 0;

	// Clock, 4 ns period
	always #2 clk_i = ~clk_i;

	stfe_engine i_stfe_engine (.clk_i(clk_i), .rst_n_i(rst_n_i), .psel_i(psel),
		.penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
		.pstrb_i(4'hF), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
		.tx_valid_o(tx_valid), .tx_data_o(tx_data), .tx_ready_i(tx_ready),
		.rx_valid_i(rx_valid), .rx_data_i(rx_data), .rx_last_i(rx_last), .irq_o(irq));
	stfe_peer i_stfe_peer (.clk_i(clk_i), .tx_valid_i(tx_valid), .tx_data_i(tx_data),
		.tx_ready_o(tx_ready), .rx_valid_o(rx_valid), .rx_data_o(rx_data),
		.rx_last_o(rx_last));

	// ==========================================
	// Reporting
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			err_count++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic end_of_test();
		if (err_count == 0 && samples_checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// ==========================================
	// APB master; the request stands until pready is seen at an edge
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
			output logic [31:0] q, output logic e);
		int n;
		n = 0;
		@(posedge clk_i);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_i);
		penable <= 1'b1;
		do begin
			@(posedge clk_i);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) begin
			err_count++;
			end_of_test();
		end
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic e;
		apb(1'b1, a, d, q, e);
	endtask
	task automatic rd(input logic [11:0] a, output logic [31:0] q);
		logic e;
		apb(1'b0, a, 32'h0000_0000, q, e);
	endtask

	// ==========================================
	// Model helpers
	function automatic logic [7:0] csum(input logic [7:0] b[$], input logic x);
		logic [7:0] s;
		s = 8'h00;
		foreach (b[k])
			s = x ? (s ^ b[k]) : (s + b[k]);
		return s;
	endfunction
	function automatic logic [31:0] ctl(input logic d, input logic x);
		return {8'h00, END_CH, node, 5'h00, x, d, 1'b0};
	endfunction
	task automatic fld(input int i, input logic [2:0] t, input logic lm, input logic ps,
			input logic [4:0] ln, input logic [31:0] v, input logic [31:0] h);
		stfe_fld_t f;
		f = '0;
		f.ftype = t;
		f.lenmode = lm;
		f.pass = ps;
		f.len = ln;
		wr(REG_FLD + 12'(16 * i), f);
		wr(REG_FLD + 12'(16 * i + 4), v);
		wr(REG_FLD + 12'(16 * i + 8), h);
	endtask
	task automatic setm(input logic [31:0] m);
		logic [31:0] q;
		mask = m;
		wr(REG_MASK, m);
		rd(REG_MASK, q);
		chk(q, m);
	endtask
	// Interrupt follows unmasked events; reading the events clears them
	task automatic fin(input logic [31:0] ev);
		logic [31:0] q;
		chk({31'h0, irq}, {31'h0, |(ev & mask)});
		rd(REG_EVT, q);
		chk(q, ev);
		repeat (2) @(posedge clk_i);
		chk({31'h0, irq}, 32'h0);
	endtask
	// Stall the sink so the busy state can be read, then collect the telegram
	task automatic run_prod(input logic [31:0] c, input logic [7:0] x[$],
			input logic [31:0] ev, input logic [1:0] st);
		logic [31:0] q;
		i_stfe_peer.got.delete();
		i_stfe_peer.hold = 1'b1;
		wr(REG_CTRL, c | 32'h1);
		rd(REG_STAT, q);
		chk(q & 32'h3, {30'h0, st});
		i_stfe_peer.hold = 1'b0;
		for (int n = 0; n < 400 && i_stfe_peer.got.size() < x.size(); n++)
			@(posedge clk_i);
		if (i_stfe_peer.got.size() < x.size()) begin
			err_count++;
			end_of_test();
		end
		repeat (20) @(posedge clk_i);
		chk(i_stfe_peer.got.size(), x.size());
		foreach (x[k])
			chk(i_stfe_peer.got[k], x[k]);
		fin(ev);
	endtask
	task automatic run_cons(input logic [31:0] c, input logic [7:0] b[$],
			input logic [31:0] ev);
		logic [31:0] q;
		wr(REG_CTRL, c | 32'h1);
		rd(REG_STAT, q);
		chk(q & 32'h3, 32'h2);
		i_stfe_peer.send(b);
		repeat (4) @(posedge clk_i);
		fin(ev);
	endtask

	// ==========================================
	// Main sequence
	initial begin
		logic [31:0] q;
		logic e;
		logic [7:0] x[$];
		logic [7:0] b[3];
		logic [7:0] cv[5];
		logic [7:0] lv[5];
		logic [11:0] ra[5];
		int s;
		s = $urandom(51);
		ra = '{REG_CTRL, REG_STAT, REG_EVT, REG_MASK, REG_DATA};
		cv = '{8'hA5, 8'hA5, 8'hA5, 8'hA5, 8'hA4};
		lv = '{8'h10, 8'h20, 8'h0F, 8'h21, 8'h15};
		repeat (20) @(posedge clk_i);
		rst_n_i <= 1'b1;
		// Reset values and an unmapped word
		foreach (ra[k]) begin
			rd(ra[k], q);
			chk(q, RST_WORD);
		end
		apb(1'b0, 12'h020, 32'h0000_0000, q, e);
		chk(q, 32'h0);
		chk({31'h0, e}, 32'h1);
		// Produce: node, big-endian constant, data block, additive sum
		node = 8'($urandom);
		setm(32'h7);
		foreach (b[k])
			b[k] = 8'($urandom);
		q = {16'h0000, 16'($urandom)};
		wr(REG_DATA, {8'h00, b[2], b[1], b[0]});
		fld(0, FT_NODE, 0, 0, 1, 0, 0);
		fld(1, FT_CONST, 0, 0, 2, q, 0);
		fld(2, FT_DATA, 0, 0, 3, 0, 0);
		fld(3, FT_CSUM, 0, 0, 1, 0, 0);
		fld(4, FT_NONE, 0, 0, 0, 0, 0);
		x = '{node, q[15:8], q[7:0], b[0], b[1], b[2]};
		x.push_back(csum(x, 1'b0));
		run_prod(ctl(1'b0, 1'b0), x, 32'h1, 2'h1);
		// Produce variable data, end char or leading length char, stripped then forwarded
		for (int p = 0; p < 4; p++) begin
			foreach (b[k])
				b[k] = 8'($urandom) | 8'h80;
			if (p > 1)
				wr(REG_DATA, {b[2], b[1], b[0], 8'h03});
			else
				wr(REG_DATA, {END_CH, b[2], b[1], b[0]});
			fld(1, FT_VAR, p[1], p[0], 5'h10, 0, 0);
			fld(2, FT_CSUM, 0, 0, 1, 0, 0);
			fld(3, FT_NONE, 0, 0, 0, 0, 0);
			x = '{node, b[0], b[1], b[2]};
			if (p == 1)
				x.push_back(END_CH);
			if (p == 3)
				x.insert(1, 8'h03);
			x.push_back(csum(x, 1'b1));
			run_prod(ctl(1'b0, 1'b1), x, 32'h1, 2'h1);
		end
		// A limit field aborts a produce with nothing sent; event is masked
		setm(32'h0);
		fld(0, FT_LIMIT, 0, 0, 1, 0, 32'hFF);
		fld(1, FT_NONE, 0, 0, 0, 0, 0);
		x.delete();
		run_prod(ctl(1'b0, 1'b0), x, 32'h4, 2'h0);
		// Consume: constant and limit checks at and beyond the bounds
		setm(32'h3);
		fld(0, FT_NODE, 0, 0, 1, 0, 0);
		fld(1, FT_CONST, 0, 0, 1, 32'hA5, 0);
		fld(2, FT_LIMIT, 0, 0, 1, 32'h10, 32'h20);
		fld(3, FT_DATA, 0, 0, 2, 0, 0);
		fld(4, FT_CSUM, 0, 0, 1, 0, 0);
		fld(5, FT_NONE, 0, 0, 0, 0, 0);
		for (int c = 0; c < 5; c++) begin
			b[0] = 8'($urandom);
			b[1] = 8'($urandom);
			wr(REG_DATA, 32'h0);
			x = '{node, cv[c], lv[c], b[0], b[1]};
			x.push_back(csum(x, 1'b0));
			s = (cv[c] == 8'hA5 && lv[c] >= 8'h10 && lv[c] <= 8'h20);
			run_cons(ctl(1'b1, 1'b0), x, (s != 0) ? 32'h1 : 32'h2);
			rd(REG_DATA, q);
			chk(q, (s != 0) ? {16'h0, b[1], b[0]} : 32'h0);
		end
		// Consume variable data: bare, end character added, length character first
		for (int m = 0; m < 3; m++) begin
			foreach (b[k])
				b[k] = 8'($urandom) | 8'h80;
			wr(REG_DATA, 32'h0);
			fld(1, FT_VAR, m == 2, m != 0, 5'h10, 0, 0);
			fld(2, FT_NONE, 0, 0, 0, 0, 0);
			x = '{node, b[0], b[1], b[2]};
			run_cons(ctl(1'b1, 1'b0), x, 32'h1);
			rd(REG_DATA, q);
			chk(q, (m == 0) ? {8'h00, b[2], b[1], b[0]} : (m == 1) ?
				{END_CH, b[2], b[1], b[0]} : {b[2], b[1], b[0], 8'h03});
		end
		end_of_test();
	end
endmodule
